// [verilog/spm_regs.vh]
`ifndef SPM_REGS_VH
`define SPM_REGS_VH
// I2C address prefix, upper four bits of the seven-bit address
`define SPM_I2C_PREFIX 4'hD
// Protocol select levels
`define SPM_MODE_I2C 1'b0
`define SPM_MODE_SPI 1'b1
// Input clock identities
`define SPM_CLK_ONE 1'b0
`define SPM_CLK_TWO 1'b1
// Output formats
`define SPM_FMT_W 2
`define SPM_FMT_LVPECL 2'h0
`define SPM_FMT_LVDS 2'h1
`define SPM_FMT_CML 2'h2
`define SPM_FMT_CMOS 2'h3
// Cleared I2C address, also shown while in SPI mode
`define SPM_ADDR_NONE 7'h00
// Start value of the reset release shift register
`define SPM_RST_CLR 2'h0
// Reset value of synchroniser stages
`define SPM_SYNC_RST 3'h0
`endif

// [verilog/spm_sync.v]
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; output changes once stages two and three agree
module spm_sync (
    input wire clk,
    input wire rst_n,
    input wire d,
    output reg q
);
`include "spm_regs.vh"
reg [2:0] sh_r;

// ----------------------------------------------------------------
// Sampling chain
// ----------------------------------------------------------------
always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        sh_r <= `SPM_SYNC_RST;
        q <= 1'b0;
    end else begin
        sh_r <= {sh_r[1:0], d};
        if (sh_r[1] == sh_r[2]) begin
            q <= sh_r[2];
        end
    end
end
endmodule
`default_nettype wire

// [verilog/spm_pin_mux.v]
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1: With lock flag pin enabled, drive lock_lost_out high when unlocked.
// R2: With lock flag pin disabled, lock_lost_out is not driven.
// R3: lock_flag_polarity sets the active level of lock_lost_out.
// R4: lock_lost_status always shows the PLL lock state.
// R5: Manual mode with pin select: select pin low picks clock one, high two.
// R6: Without pin select the register bit chooses; select pin stays undriven.
// R7: Host must hold the select pin firmly when it is an input.
// R8: Auto mode drives select pin with active input, low one, high two.
// R9: With alarms on both inputs, keep the last used active input.
// R10: Active flag driven only while its pin enable bit is set.
// R11: active_input_status always mirrors the active input.
// R12: Protocol select pin low means I2C, high means SPI.
// R13: Host must tie the protocol select pin firmly high or low.
// R14: One serial clock pin serves both modes, driven by host.
// R15: Data pin is bidirectional in I2C, output only in SPI.
// R16: I2C address is 1101 plus three address pins; SPI ignores low two.
// R17: Top address pin is address bit two in I2C, slave select in SPI.
// R18: Serial input pin is ignored in I2C and is SPI data in SPI.
// R19: Each output follows its format field; CMOS drives both pins alike.
// R20: Each pin role applies only in its own protocol mode.
`include "spm_regs.vh"
module spm_pin_mux (
    input wire ref_clk,
    input wire reset_n,
    // PLL core state
    input wire pll_locked,
    input wire auto_select_mode,
    input wire alarm_one,
    input wire alarm_two,
    // Configuration bits
    input wire lock_flag_pin_enable,
    input wire lock_flag_polarity,
    input wire input_select_by_pin,
    input wire input_select_bit,
    input wire active_flag_pin_enable,
    input wire [`SPM_FMT_W-1:0] out_one_format,
    input wire [`SPM_FMT_W-1:0] out_two_format,
    // Synthesised clocks from the core
    input wire core_clk_one,
    input wire core_clk_two,
    // Status
    output reg lock_lost_status,
    output reg active_input_status,
    output reg selected_input,
    // Lock pin
    output reg lock_lost_out_o,
    output reg lock_lost_out_oe,
    // Shared select / active pin
    input wire select_or_active_pin_i,
    output reg select_or_active_pin_o,
    output reg select_or_active_pin_oe,
    // Serial port pins
    input wire port_protocol_select,
    input wire serial_clk_pin,
    input wire shared_serial_data_pin_i,
    output wire shared_serial_data_pin_o,
    output wire shared_serial_data_pin_oe,
    input wire addr_bit_zero_pin,
    input wire addr_bit_one_pin,
    input wire addr_two_or_select_pin,
    input wire serial_in_pin,
    // Serial engine side
    output reg port_is_spi,
    output reg [6:0] i2c_address,
    output reg port_clk_level,
    output reg port_clk_rise,
    output reg port_clk_fall,
    output reg port_data_in,
    output reg spi_select_n,
    input wire port_data_out,
    input wire port_data_out_en,
    // Clock outputs, positive and negative pins
    output reg clock_output_one_p,
    output reg clock_output_one_n,
    output reg clock_output_two_p,
    output reg clock_output_two_n
);

// ----------------------------------------------------------------
// Reset release
// ----------------------------------------------------------------
reg [1:0] rst_sh_r;
wire rst_n;

always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
        rst_sh_r <= `SPM_RST_CLR;
    end else begin
        rst_sh_r <= {rst_sh_r[0], 1'b1};
    end
end
assign rst_n = rst_sh_r[1];

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
wire sel_pin_s;
wire mode_s;
wire scl_s;
wire sda_s;
wire a0_s;
wire a1_s;
wire a2_s;
wire sdi_s;

// Clock select pin, only meaningful while it is an input
spm_sync u_sync_sel (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(select_or_active_pin_i),
    .q(sel_pin_s)
);
// Protocol mode strap
spm_sync u_sync_mode (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(port_protocol_select),
    .q(mode_s)
);
// Serial clock from the host
spm_sync u_sync_scl (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(serial_clk_pin),
    .q(scl_s)
);
// Shared data line as seen on the pin
spm_sync u_sync_sda (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(shared_serial_data_pin_i),
    .q(sda_s)
);
// Address bit zero
spm_sync u_sync_a0 (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(addr_bit_zero_pin),
    .q(a0_s)
);
// Address bit one
spm_sync u_sync_a1 (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(addr_bit_one_pin),
    .q(a1_s)
);
// Address bit two or slave select
spm_sync u_sync_a2 (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(addr_two_or_select_pin),
    .q(a2_s)
);
// Serial data input
spm_sync u_sync_sdi (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(serial_in_pin),
    .q(sdi_s)
);

// ----------------------------------------------------------------
// Lock indication
// ----------------------------------------------------------------
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        lock_lost_status <= 1'b1;
        lock_lost_out_o <= 1'b0;
        lock_lost_out_oe <= 1'b0;
    end else begin
        lock_lost_status <= ~pll_locked; // see R4
        // Polarity bit set inverts the flag to active low
        lock_lost_out_o <= (~pll_locked) ^ lock_flag_polarity; // see R1 see R3
        lock_lost_out_oe <= lock_flag_pin_enable; // see R1 see R2
    end
end

// ----------------------------------------------------------------
// Input clock choice and active indication
// ----------------------------------------------------------------
reg active_r;
reg active_nxt;

// Auto mode follows the healthy input; double alarm holds the last one
always @* begin
    active_nxt = active_r;
    if (auto_select_mode) begin
        if (!alarm_one && alarm_two) begin
            active_nxt = `SPM_CLK_ONE;
        end else if (alarm_one && !alarm_two) begin
            active_nxt = `SPM_CLK_TWO;
        end else if (!alarm_one && !alarm_two) begin
            active_nxt = active_r; // stay on current healthy input
        end else begin
            active_nxt = active_r; // see R9
        end
    end else if (input_select_by_pin) begin
        active_nxt = sel_pin_s; // see R5
    end else begin
        active_nxt = input_select_bit; // see R6
    end
end

always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        active_r <= `SPM_CLK_ONE;
        active_input_status <= `SPM_CLK_ONE;
        selected_input <= `SPM_CLK_ONE;
        select_or_active_pin_o <= 1'b0;
        select_or_active_pin_oe <= 1'b0;
    end else begin
        active_r <= active_nxt;
        selected_input <= active_nxt;
        active_input_status <= active_nxt; // see R11
        select_or_active_pin_o <= active_nxt; // see R8
        // Pin is only an output in auto mode with the enable set; else input
        select_or_active_pin_oe <= auto_select_mode & active_flag_pin_enable; // see R10 see R6
    end
end

// ----------------------------------------------------------------
// Protocol mode
// ----------------------------------------------------------------
// Strap level picks the register-port protocol
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        port_is_spi <= `SPM_MODE_I2C;
    end else begin
        port_is_spi <= mode_s; // see R12
    end
end

// ----------------------------------------------------------------
// Serial clock level and edges
// ----------------------------------------------------------------
reg scl_d_r;

// Delay stage starts at the idle low level, so no false edge after reset
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        scl_d_r <= 1'b0;
        port_clk_level <= 1'b0;
        port_clk_rise <= 1'b0;
        port_clk_fall <= 1'b0;
    end else begin
        scl_d_r <= scl_s;
        port_clk_level <= scl_s; // see R14
        port_clk_rise <= scl_s & ~scl_d_r; // see R14
        port_clk_fall <= ~scl_s & scl_d_r;
    end
end

// ----------------------------------------------------------------
// Serial port pin routing
// ----------------------------------------------------------------
// Address and data pins take the role of the current mode only
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        i2c_address <= `SPM_ADDR_NONE;
        port_data_in <= 1'b0;
        spi_select_n <= 1'b1;
    end else begin
        if (mode_s == `SPM_MODE_SPI) begin
            i2c_address <= `SPM_ADDR_NONE; // see R16
            spi_select_n <= a2_s; // see R17 see R20
            port_data_in <= sdi_s; // see R18
        end else begin
            i2c_address <= {`SPM_I2C_PREFIX, a2_s, a1_s, a0_s}; // see R16 see R17
            spi_select_n <= 1'b1; // see R20
            port_data_in <= sda_s; // see R18 see R15
        end
    end
end

// I2C is open drain: only pull low; SPI drives push-pull while selected
assign shared_serial_data_pin_o = port_is_spi ? port_data_out : 1'b0; // see R15
assign shared_serial_data_pin_oe = port_is_spi ?
    (port_data_out_en & ~spi_select_n) : (port_data_out_en & ~port_data_out); // see R15

// ----------------------------------------------------------------
// Clock output formats
// ----------------------------------------------------------------
// Output one: CMOS gives two identical copies, others a complementary pair
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        clock_output_one_p <= 1'b0;
        clock_output_one_n <= 1'b0;
    end else begin
        clock_output_one_p <= core_clk_one;
        clock_output_one_n <= (out_one_format == `SPM_FMT_CMOS) ?
            core_clk_one : ~core_clk_one; // see R19
    end
end

// Output two follows its own format field the same way
always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
        clock_output_two_p <= 1'b0;
        clock_output_two_n <= 1'b0;
    end else begin
        clock_output_two_p <= core_clk_two;
        clock_output_two_n <= (out_two_format == `SPM_FMT_CMOS) ?
            core_clk_two : ~core_clk_two; // see R19
    end
end

endmodule
`default_nettype wire

// [verif/spm_pin_mux_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// --
// Pin mux port checks
// --
module spm_pin_mux_asserts (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic pll_locked,
    input wire logic auto_select_mode,
    input wire logic alarm_one,
    input wire logic alarm_two,
    input wire logic lock_flag_pin_enable,
    input wire logic lock_flag_polarity,
    input wire logic active_flag_pin_enable,
    input wire logic lock_lost_status,
    input wire logic active_input_status,
    input wire logic lock_lost_out_o,
    input wire logic lock_lost_out_oe,
    input wire logic select_or_active_pin_o,
    input wire logic select_or_active_pin_oe,
    input wire logic shared_serial_data_pin_o,
    input wire logic port_is_spi,
    input wire logic spi_select_n
);
    // One clock; outputs lag inputs by one cycle once the reset copy is out
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_lock_status: assert property (
        $past(reset_n, 4) |-> lock_lost_status == !$past(pll_locked)) else $error("lock status");
    a_lock_enable: assert property (
        $past(reset_n, 4) |-> lock_lost_out_oe == $past(lock_flag_pin_enable)) else $error("lock oe");
    a_lock_level: assert property (
        $past(reset_n, 4) |-> lock_lost_out_o == ($past(lock_flag_polarity) ^ !$past(pll_locked)))
        else $error("lock level");
    a_active_enable: assert property (
        $past(reset_n, 4) |-> select_or_active_pin_oe ==
        ($past(auto_select_mode) && $past(active_flag_pin_enable))) else $error("active oe");
    a_active_level: assert property (
        select_or_active_pin_oe |-> select_or_active_pin_o == active_input_status)
        else $error("active level");
    a_alarm_hold: assert property (
        auto_select_mode && alarm_one && alarm_two |=> $stable(active_input_status))
        else $error("active input moved");
    a_i2c_data_low: assert property (
        !port_is_spi |-> !shared_serial_data_pin_o) else $error("data driven high");
    a_spi_select_off: assert property (
        !port_is_spi && $stable(port_is_spi) |-> spi_select_n) else $error("select in i2c");
endmodule
bind spm_pin_mux spm_pin_mux_asserts u_chk (.*);
`default_nettype wire

// [verif/spm_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// --
// Host side of the serial port
// --
module spm_host_model (
    input wire logic frame_on,
    input wire logic [7:0] tx_byte,
    output var logic serial_clk_pin,
    output var logic serial_in_pin
);
    // One byte MSB first at 400 ns; both lines rest low between frames
    initial begin
        serial_clk_pin = 1'b0;
        serial_in_pin = 1'b0;
        forever begin
            wait (frame_on);
            for (int i = 7; i >= 0; i--) begin
                serial_in_pin = tx_byte[i];
                #100 serial_clk_pin = 1'b1;
                #200 serial_clk_pin = 1'b0;
                #100;
            end
            serial_in_pin = 1'b0; // Back to its pull-down
            wait (!frame_on);
        end
    end
endmodule
`default_nettype wire

// [verif/status_pin_and_host_port_mux_test.sv]
`timescale 1ns/1ps
`default_nettype none
// --
// Pin mux bench
// --
module status_pin_and_host_port_mux_test;
    logic ref_clk, reset_n, pll_locked, auto_select_mode, alarm_one, alarm_two, core_clk_one;
    logic lock_flag_pin_enable, lock_flag_polarity, input_select_by_pin, input_select_bit;
    logic active_flag_pin_enable, port_protocol_select, serial_clk_pin, serial_in_pin, sel_drv;
    logic addr_bit_zero_pin, addr_bit_one_pin, addr_two_or_select_pin, port_data_out;
    logic port_data_out_en, lock_lost_status, active_input_status, lock_lost_out_o, port_is_spi;
    logic lock_lost_out_oe, select_or_active_pin_o, select_or_active_pin_oe, spi_select_n;
    logic shared_serial_data_pin_o, shared_serial_data_pin_oe, port_clk_rise, port_data_in;
    logic clock_output_one_p, clock_output_one_n, clock_output_two_p, clock_output_two_n;
    logic frame_on, selected_input, port_clk_level, port_clk_fall;
    logic [1:0] out_one_format, out_two_format;
    logic [6:0] i2c_address;
    logic [7:0] tx_byte, rx_byte, fall_cnt;
    int error_cnt, n_tests;
    // Pin levels: device drive, else host firm level or pull-up
    wire select_or_active_pin_i = select_or_active_pin_oe ? select_or_active_pin_o : sel_drv;
    wire shared_serial_data_pin_i = shared_serial_data_pin_oe ? shared_serial_data_pin_o : 1'b1;
    spm_pin_mux u_dut (.core_clk_two(core_clk_one), .*);
    spm_host_model u_host (.*);
    // Clock and a core clock toggling every cycle
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) core_clk_one <= ~core_clk_one;
    // Shift in bits sampled on serial clock rises, count the falls
    always @(posedge ref_clk) if (port_clk_rise === 1'b1) rx_byte <= {rx_byte[6:0], port_data_in};
    always @(posedge ref_clk) if (port_clk_fall === 1'b1) fall_cnt <= fall_cnt + 8'h01;
    task cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h, expected %h", $time, seen, exp);
        end
    endtask
    task send(input logic [7:0] b);
        tx_byte = b;
        frame_on = 1'b1;
        cyc(8);
        chk(port_clk_level, 1'b1);
        cyc(64);
        frame_on = 1'b0;
        cyc(8);
    endtask
    task summarize();
        $display("%0d mismatches in %0d comparisons", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        {pll_locked, auto_select_mode, alarm_one, alarm_two, core_clk_one, reset_n} = '0;
        {lock_flag_pin_enable, lock_flag_polarity, input_select_by_pin, input_select_bit} = '0;
        {active_flag_pin_enable, port_protocol_select, port_data_out, port_data_out_en} = '0;
        {addr_bit_zero_pin, addr_bit_one_pin, addr_two_or_select_pin, frame_on, sel_drv} = '0;
        {out_one_format, out_two_format, tx_byte, rx_byte, fall_cnt, error_cnt, n_tests} = '0;
        cyc(16);
        reset_n = 1'b1;
        cyc(8);
        for (int k = 0; k < 8; k++) begin
            {lock_flag_pin_enable, lock_flag_polarity, pll_locked} = 3'(k);
            cyc(2);
            chk(lock_lost_status, !pll_locked);
            chk(lock_lost_out_oe, lock_flag_pin_enable);
            chk(lock_lost_out_o, lock_flag_polarity ^ !pll_locked);
        end
        input_select_by_pin = 1'b1;
        sel_drv = 1'b1; // Held firm while an input
        cyc(8);
        chk({active_input_status, selected_input}, 2'h3);
        input_select_by_pin = 1'b0;
        cyc(8);
        chk({active_input_status, select_or_active_pin_oe}, 2'h0);
        {auto_select_mode, active_flag_pin_enable, alarm_one, sel_drv} = 4'hE;
        cyc(3);
        chk(select_or_active_pin_i, 1'b1);
        alarm_two = 1'b1;
        cyc(3);
        chk(active_input_status, 1'b1);
        alarm_one = 1'b0;
        cyc(3);
        chk({select_or_active_pin_oe, select_or_active_pin_o}, 2'h2);
        {alarm_one, active_flag_pin_enable} = 2'h0;
        cyc(3);
        chk({active_input_status, select_or_active_pin_oe}, 2'h0);
        {addr_two_or_select_pin, addr_bit_one_pin, addr_bit_zero_pin, port_data_out_en} = 4'hB;
        cyc(8);
        chk({i2c_address, shared_serial_data_pin_i}, 8'hDA);
        port_data_out = 1'b1;
        send(8'hA5);
        chk(rx_byte, 8'hFF);
        chk(fall_cnt, 8'h08);
        {port_protocol_select, addr_two_or_select_pin} = 2'h2; // Firm mode level
        cyc(8);
        chk({port_is_spi, spi_select_n, shared_serial_data_pin_oe}, 3'h5);
        chk(i2c_address, 8'h00);
        send(8'h3C);
        chk(rx_byte, 8'h3C);
        chk(fall_cnt, 8'h10);
        {addr_two_or_select_pin, port_data_out} = 2'h2;
        cyc(8);
        chk({spi_select_n, shared_serial_data_pin_oe}, 2'h2);
        addr_two_or_select_pin = 1'b0;
        cyc(8);
        chk(shared_serial_data_pin_i, 1'b0);
        for (int k = 0; k < 4; k++) begin
            {out_one_format, out_two_format} = {2'(k), 2'(3 - k)};
            cyc(3);
            chk({clock_output_one_p ^ clock_output_one_n, clock_output_two_p ^ clock_output_two_n},
                {k != 3, k != 0});
        end
        summarize();
    end
    // Watchdog
    initial begin
        #100000;
        error_cnt++;
        summarize();
    end
endmodule
`default_nettype wire
